// ==== hw/tla_limit_regs.v ====
`timescale 1ns/1ps
`include "tla_regs.vh"

// Functional notes
// - In cruise mode with board fan protection on, a reading above its threshold forces full drive.
// - In cruise mode with processor fan protection on, a reading above its threshold forces full drive.
// - The board fan critical threshold is read-write and resets to all ones.
// - Bank 1 reading is read-only, 9 bits of half degrees: bits 8..1 high byte, bit 0 in low bit 7.
// - The bank 1 reading comes from the cpu input or the PECI value per the cpu source select.
// - Bank 2 high byte holds bits 8..1 of the reading named by the board source select.
// - Config bits 4..3 give the count of consecutive faults needed, minus one, before the alert asserts.
// - Config bit 1 picks comparator mode (0, reset) or interrupt mode (1).
// - Config bit 0 set stops monitoring of the cpu input; clear keeps it running.
// - The hysteresis limit is a writable 9-bit value resetting to 75 degrees (0x4b, 0x00).
// - The over-temperature limit is a writable 9-bit value resetting to 80 degrees (0x50, 0x00).
// - Enable bit 5 guards the processor fan, bit 4 the board fan; both reset off.
// - Bank 2 low byte bit 7 holds bit 0 of the selected reading; bits 6..0 read zero.

module tla_limit_regs (
  input  wire        pclk,                  // monitor clock, 100 MHz
  input  wire        presetn,               // async reset, low
  input  wire [11:0] paddr,                 // apb byte address
  input  wire        psel,                  // apb select
  input  wire        penable,               // apb enable
  input  wire        pwrite,                // apb direction
  input  wire [31:0] pwdata,                // apb write data
  output reg  [31:0] prdata,                // apb read data
  output reg         pready,                // apb ready
  output reg         pslverr,               // apb error, unmapped
  input  wire [8:0]  cpu_temp_input,        // cpu diode reading
  input  wire [8:0]  board_temp_input,      // board reading
  input  wire [8:0]  peci_temp,             // processor reading
  input  wire        sample_valid,          // new cpu reading pulse
  input  wire        cpu_src_sel,           // 1 selects peci
  input  wire [1:0]  board_src_sel,         // board fan source
  input  wire        board_fan_cruise,      // board fan cruise mode
  input  wire        processor_fan_cruise,  // cpu fan cruise mode
  input  wire [7:0]  board_fan_duty,        // board duty request
  input  wire [7:0]  processor_fan_duty,    // cpu duty request
  output wire [7:0]  board_fan_drive,       // board fan duty out
  output wire [7:0]  processor_fan_drive,   // cpu fan duty out
  output reg         overheat_alert_out_n,  // alert pin, low
  output reg         irq                    // level interrupt
);

  // ---------------------------------------------------------------
  // register map, index is byte address over four
  // ---------------------------------------------------------------
  // any bank:
  //   0x40  bank select, bits 2..0
  //   0x41  event status, write one to clear: bit 0 alert trip,
  //         bit 1 board fan critical entry, bit 2 processor fan entry
  //   0x42  event mask, a one lets the event reach irq
  // bank 0:
  //   0x5e  critical enables, bit 5 processor fan, bit 4 board fan
  //   0x6b  board fan critical threshold, whole degrees
  //   0x6c  processor fan critical threshold, whole degrees
  // bank 1:
  //   0x50  cpu side reading bits 8..1, read only
  //   0x51  cpu side reading bit 0 in bit 7, read only
  //   0x52  config: fault count 4..3, mode 1, stop 0
  //   0x53  hysteresis limit bits 8..1
  //   0x54  hysteresis limit bit 0 in bit 7
  //   0x55  over-temperature limit bits 8..1
  //   0x56  over-temperature limit bit 0 in bit 7
  // bank 2:
  //   0x50  selected reading bits 8..1, read only
  //   0x51  selected reading bit 0 in bit 7, read only
  // other indices, or paddr bits 11..10 set, answer with pslverr;
  // a banked index in the wrong bank is unmapped, so software must
  // set the bank before touching a banked register

  // ---------------------------------------------------------------
  // storage
  // ---------------------------------------------------------------
  reg  [`TLA_BANK_W-1:0] bank;
  reg  [`TLA_IRQ_W-1:0]  irq_status;
  reg  [`TLA_IRQ_W-1:0]  irq_mask;
  reg  [1:0]             crit_en;
  reg  [7:0]             sys_crit;
  reg  [7:0]             cpu_crit;
  reg  [7:0]             cfg;
  reg  [7:0]             hyst_hi;
  reg                    hyst_lsb;
  reg  [7:0]             over_hi;
  reg                    over_lsb;

  // ---------------------------------------------------------------
  // bus decode
  // ---------------------------------------------------------------
  wire [7:0]  idx;
  wire        addr_hi;
  wire        acc;
  wire        wr;
  wire        rd_stat;
  reg  [7:0]  rd_val;
  reg         rd_hit;
  reg  [8:0]  cpu_side_temp;
  reg  [8:0]  selected_temp;
  wire        alert;
  wire        alert_trip;
  wire        sys_rise;
  wire        cpu_rise;
  wire [`TLA_IRQ_W-1:0] irq_events;
  wire [`TLA_IRQ_W-1:0] next_irq_status;

  assign idx     = paddr[`TLA_IDX_MSB:`TLA_IDX_LSB];
  assign addr_hi = |paddr[`TLA_ADDR_MSB:`TLA_IDX_MSB+1];
  // completing edge: ready already high from the wait cycle
  assign acc     = psel & penable & pready;
  assign wr      = acc & pwrite & ~pslverr;
  assign rd_stat = acc & ~pwrite & (idx == `TLA_IDX_IRQ_STAT) & ~addr_hi;

  // low byte form: reading bit 0 in bit 7, rest zero
  function [7:0] lsb_byte;
    input bit0;
    begin
      lsb_byte = {bit0, 7'h00};
    end
  endfunction

  // bank-qualified match of a banked index
  function at;
    input [`TLA_BANK_W-1:0] b;
    input [7:0]             i;
    input [`TLA_BANK_W-1:0] want_b;
    input [7:0]             want_i;
    begin
      at = (b == want_b) && (i == want_i);
    end
  endfunction

  // ---------------------------------------------------------------
  // source selection
  // ---------------------------------------------------------------
  // readings come from converter logic on this clock
  always @* begin
    cpu_side_temp = cpu_src_sel ? peci_temp : cpu_temp_input;
    case (board_src_sel)
      `TLA_SRC_BOARD: selected_temp = board_temp_input;
      `TLA_SRC_CPU:   selected_temp = cpu_temp_input;
      `TLA_SRC_PECI:  selected_temp = peci_temp;
      default:        selected_temp = board_temp_input;
    endcase
  end

  // ---------------------------------------------------------------
  // read mux
  // ---------------------------------------------------------------
  // readings shown live; a snapshot would lag the fan logic
  always @* begin
    rd_val = 8'h00;
    rd_hit = 1'b1;
    if (addr_hi) begin
      rd_hit = 1'b0;
    end else if (idx == `TLA_IDX_BANK) begin
      rd_val = {{(8-`TLA_BANK_W){1'b0}}, bank};
    end else if (idx == `TLA_IDX_IRQ_STAT) begin
      rd_val = {{(8-`TLA_IRQ_W){1'b0}}, irq_status};
    end else if (idx == `TLA_IDX_IRQ_MASK) begin
      rd_val = {{(8-`TLA_IRQ_W){1'b0}}, irq_mask};
    end else if (at(bank, idx, `TLA_BANK0, `TLA_IDX_CRIT_EN)) begin
      rd_val = {2'b00, crit_en, 4'h0};
    end else if (at(bank, idx, `TLA_BANK0, `TLA_IDX_SYS_CRIT)) begin
      rd_val = sys_crit;
    end else if (at(bank, idx, `TLA_BANK0, `TLA_IDX_CPU_CRIT)) begin
      rd_val = cpu_crit;
    end else if (at(bank, idx, `TLA_BANK1, `TLA_IDX_TEMP_HI)) begin
      rd_val = cpu_side_temp[8:1];
    end else if (at(bank, idx, `TLA_BANK1, `TLA_IDX_TEMP_LO)) begin
      rd_val = lsb_byte(cpu_side_temp[0]);
    end else if (at(bank, idx, `TLA_BANK1, `TLA_IDX_CFG)) begin
      rd_val = cfg;
    end else if (at(bank, idx, `TLA_BANK1, `TLA_IDX_HYST_HI)) begin
      rd_val = hyst_hi;
    end else if (at(bank, idx, `TLA_BANK1, `TLA_IDX_HYST_LO)) begin
      rd_val = lsb_byte(hyst_lsb);
    end else if (at(bank, idx, `TLA_BANK1, `TLA_IDX_OVER_HI)) begin
      rd_val = over_hi;
    end else if (at(bank, idx, `TLA_BANK1, `TLA_IDX_OVER_LO)) begin
      rd_val = lsb_byte(over_lsb);
    end else if (at(bank, idx, `TLA_BANK2, `TLA_IDX_TEMP_HI)) begin
      rd_val = selected_temp[8:1];
    end else if (at(bank, idx, `TLA_BANK2, `TLA_IDX_TEMP_LO)) begin
      rd_val = lsb_byte(selected_temp[0]);
    end else begin
      rd_hit = 1'b0;
    end
  end

  // ---------------------------------------------------------------
  // apb answer: one wait state, data and error with ready
  // ---------------------------------------------------------------
  // first access edge loads data and error; ready stands one cycle
  // and the write lands on the edge that sees it, so every access
  // costs exactly one wait state whatever the register
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pready  <= 1'b0;
      pslverr <= 1'b0;
      prdata  <= 32'h0000_0000;
    end else begin
      pready <= psel & penable & ~pready;
      if (psel && penable && !pready) begin
        pslverr <= ~rd_hit;
        prdata  <= (pwrite || !rd_hit) ? 32'h0000_0000 : {24'h00_0000, rd_val};
      end else begin
        pslverr <= 1'b0;
      end
    end
  end

  // ---------------------------------------------------------------
  // register writes
  // ---------------------------------------------------------------
  // reading registers have no write path, writes drop silently
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      bank     <= `TLA_BANK0;
      irq_mask <= {`TLA_IRQ_W{1'b0}};
      crit_en  <= 2'b00;
      sys_crit <= `TLA_RST_CRIT;
      cpu_crit <= `TLA_RST_CRIT;
      cfg      <= `TLA_RST_CFG;
      hyst_hi  <= `TLA_RST_HYST_HI;
      hyst_lsb <= 1'b0;
      over_hi  <= `TLA_RST_OVER_HI;
      over_lsb <= 1'b0;
    end else if (wr) begin
      if (idx == `TLA_IDX_BANK) begin
        bank <= pwdata[`TLA_BANK_W-1:0];
      end
      if (idx == `TLA_IDX_IRQ_MASK) begin
        irq_mask <= pwdata[`TLA_IRQ_W-1:0];
      end
      if (at(bank, idx, `TLA_BANK0, `TLA_IDX_CRIT_EN)) begin
        crit_en <= pwdata[`TLA_CRIT_CPU_BIT:`TLA_CRIT_SYS_BIT];
      end
      if (at(bank, idx, `TLA_BANK0, `TLA_IDX_SYS_CRIT)) begin
        sys_crit <= pwdata[7:0];
      end
      if (at(bank, idx, `TLA_BANK0, `TLA_IDX_CPU_CRIT)) begin
        cpu_crit <= pwdata[7:0];
      end
      // reserved config bits are not stored and read zero
      if (at(bank, idx, `TLA_BANK1, `TLA_IDX_CFG)) begin
        cfg <= pwdata[7:0] & `TLA_CFG_WMASK;
      end
      if (at(bank, idx, `TLA_BANK1, `TLA_IDX_HYST_HI)) begin
        hyst_hi <= pwdata[7:0];
      end
      if (at(bank, idx, `TLA_BANK1, `TLA_IDX_HYST_LO)) begin
        hyst_lsb <= pwdata[`TLA_LSB_POS];
      end
      if (at(bank, idx, `TLA_BANK1, `TLA_IDX_OVER_HI)) begin
        over_hi <= pwdata[7:0];
      end
      if (at(bank, idx, `TLA_BANK1, `TLA_IDX_OVER_LO)) begin
        over_lsb <= pwdata[`TLA_LSB_POS];
      end
    end
  end

  // ---------------------------------------------------------------
  // alert filter
  // ---------------------------------------------------------------
  // filter watches the raw cpu input, not the selected reading:
  // the limits belong to that input alone
  tla_alert_filter u_alert (
    .pclk       (pclk),
    .presetn    (presetn),
    .sample     (sample_valid),
    .stop       (cfg[`TLA_CFG_STOP]),
    .mode       (cfg[`TLA_CFG_MODE]),
    .fault_cnt  (cfg[`TLA_CFG_FAULT_MSB:`TLA_CFG_FAULT_LSB]),
    .temp       (cpu_temp_input),
    .overheat   ({over_hi, over_lsb}),
    .hysteresis ({hyst_hi, hyst_lsb}),
    .ack        (rd_stat),
    .alert      (alert),
    .trip       (alert_trip)
  );

  // pin is registered again so it never glitches on decode
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      overheat_alert_out_n <= 1'b1;
    end else begin
      overheat_alert_out_n <= ~alert;
    end
  end

  // ---------------------------------------------------------------
  // critical fan override
  // ---------------------------------------------------------------
  // fans compare whole degrees, reading bits 8..1, with their
  // thresholds; the all-ones reset threshold can never trip
  tla_fan_critical u_board_fan (
    .pclk      (pclk),
    .presetn   (presetn),
    .cruise    (board_fan_cruise),
    .enable    (crit_en[0]),
    .threshold (sys_crit),
    .temp      (selected_temp[8:1]),
    .duty_in   (board_fan_duty),
    .drive     (board_fan_drive),
    .critical  (),
    .crit_rise (sys_rise)
  );

  tla_fan_critical u_processor_fan (
    .pclk      (pclk),
    .presetn   (presetn),
    .cruise    (processor_fan_cruise),
    .enable    (crit_en[1]),
    .threshold (cpu_crit),
    .temp      (cpu_side_temp[8:1]),
    .duty_in   (processor_fan_duty),
    .drive     (processor_fan_drive),
    .critical  (),
    .crit_rise (cpu_rise)
  );

  // ---------------------------------------------------------------
  // interrupt status, write one to clear, set wins
  // ---------------------------------------------------------------
  assign irq_events = {cpu_rise, sys_rise, alert_trip};
  assign next_irq_status =
    (irq_status & ~((wr && idx == `TLA_IDX_IRQ_STAT) ? pwdata[`TLA_IRQ_W-1:0]
                                                      : {`TLA_IRQ_W{1'b0}}))
    | irq_events;

  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      irq_status <= {`TLA_IRQ_W{1'b0}};
      irq        <= 1'b0;
    end else begin
      irq_status <= next_irq_status;
      irq        <= |(irq_status & irq_mask);
    end
  end

endmodule // tla_limit_regs

// ==== hw/tla_regs.vh ====
`ifndef TLA_REGS_VH
`define TLA_REGS_VH

// ---------------------------------------------------------------
// register indices (byte address = index * 4)
// ---------------------------------------------------------------
`define TLA_IDX_BANK        8'h40
`define TLA_IDX_IRQ_STAT    8'h41
`define TLA_IDX_IRQ_MASK    8'h42
`define TLA_IDX_CRIT_EN     8'h5e
`define TLA_IDX_SYS_CRIT    8'h6b
`define TLA_IDX_CPU_CRIT    8'h6c
`define TLA_IDX_TEMP_HI     8'h50
`define TLA_IDX_TEMP_LO     8'h51
`define TLA_IDX_CFG         8'h52
`define TLA_IDX_HYST_HI     8'h53
`define TLA_IDX_HYST_LO     8'h54
`define TLA_IDX_OVER_HI     8'h55
`define TLA_IDX_OVER_LO     8'h56

// ---------------------------------------------------------------
// banks and address layout
// ---------------------------------------------------------------
`define TLA_BANK_W          3
`define TLA_BANK0           3'h0
`define TLA_BANK1           3'h1
`define TLA_BANK2           3'h2
`define TLA_IDX_MSB         9
`define TLA_IDX_LSB         2
`define TLA_ADDR_MSB        11

// ---------------------------------------------------------------
// fields
// ---------------------------------------------------------------
`define TLA_CFG_WMASK       8'h1b
`define TLA_CFG_STOP        0
`define TLA_CFG_MODE        1
`define TLA_CFG_FAULT_LSB   3
`define TLA_CFG_FAULT_MSB   4
`define TLA_CRIT_SYS_BIT    4
`define TLA_CRIT_CPU_BIT    5
`define TLA_LSB_POS         7
`define TLA_IRQ_W           3
`define TLA_IRQ_ALERT       0
`define TLA_IRQ_SYS_CRIT    1
`define TLA_IRQ_CPU_CRIT    2

// ---------------------------------------------------------------
// reset values and constants
// ---------------------------------------------------------------
`define TLA_RST_CFG         8'h00
`define TLA_RST_HYST_HI     8'h4b
`define TLA_RST_OVER_HI     8'h50
`define TLA_RST_CRIT        8'hff
`define TLA_FULL_DRIVE      8'hff
`define TLA_SRC_BOARD       2'h0
`define TLA_SRC_CPU         2'h1
`define TLA_SRC_PECI        2'h2

`endif

// ==== hw/tla_fan_critical.v ====
`timescale 1ns/1ps
`include "tla_regs.vh"

module tla_fan_critical (
  input  wire       pclk,       // monitor clock
  input  wire       presetn,    // async reset, low
  input  wire       cruise,     // fan is in cruise mode
  input  wire       enable,     // critical protection on
  input  wire [7:0] threshold,  // critical threshold
  input  wire [7:0] temp,       // monitored temperature
  input  wire [7:0] duty_in,    // duty from fan control
  output reg  [7:0] drive,      // duty toward the fan
  output reg        critical,   // override active
  output reg        crit_rise   // one-cycle entry pulse
);

  wire force_full;

  // strict compare: reset threshold of all ones never trips
  assign force_full = cruise & enable & (temp > threshold);

  // ---------------------------------------------------------------
  // drive override
  // ---------------------------------------------------------------
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      drive     <= 8'h00;
      critical  <= 1'b0;
      crit_rise <= 1'b0;
    end else begin
      drive     <= force_full ? `TLA_FULL_DRIVE : duty_in;
      critical  <= force_full;
      crit_rise <= force_full & ~critical;
    end
  end

endmodule // tla_fan_critical

// ==== hw/tla_alert_filter.v ====
`timescale 1ns/1ps
`include "tla_regs.vh"

module tla_alert_filter (
  input  wire       pclk,        // monitor clock
  input  wire       presetn,     // async reset, low
  input  wire       sample,      // new reading strobe
  input  wire       stop,        // monitoring halted
  input  wire       mode,        // 0 comparator, 1 interrupt
  input  wire [1:0] fault_cnt,   // faults needed minus one
  input  wire [8:0] temp,        // cpu input reading
  input  wire [8:0] overheat,    // over-temperature limit
  input  wire [8:0] hysteresis,  // release limit
  input  wire       ack,         // status read, clears latch
  output reg        alert,       // alert state, high active
  output reg        trip         // one-cycle assert pulse
);

  wire       hot;
  wire       cool;
  wire [2:0] need;
  wire [2:0] cnt_inc;
  reg  [2:0] cnt;

  assign hot     = temp > overheat;
  assign cool    = temp < hysteresis;
  assign need    = {1'b0, fault_cnt} + 3'h1;
  assign cnt_inc = (cnt == need) ? cnt : cnt + 3'h1;

  // ---------------------------------------------------------------
  // fault counter and alert latch
  // ---------------------------------------------------------------
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      cnt   <= 3'h0;
      alert <= 1'b0;
      trip  <= 1'b0;
    end else begin
      trip <= 1'b0;
      // interrupt mode holds until the status read; a trip decided
      // below is assigned later and so wins over a clear in one cycle
      if (mode && ack && !trip) begin
        alert <= 1'b0;
      end
      if (sample && !stop) begin
        cnt <= hot ? cnt_inc : 3'h0;
        if (hot && cnt_inc == need && !alert) begin
          alert <= 1'b1;
          trip  <= 1'b1;
        end else if (!mode && alert && cool) begin
          alert <= 1'b0;
        end
      end
    end
  end

endmodule // tla_alert_filter

// ==== tb/tla_limit_regs_asserts.sv ====
`timescale 1ns/1ps
module tla_limit_regs_asserts (
  input wire        pclk,                  // monitor clock
  input wire        presetn,               // async reset, low
  input wire        psel,                  // apb select
  input wire        penable,               // apb enable
  input wire        pwrite,                // apb direction
  input wire [31:0] prdata,                // apb read data
  input wire        pready,                // apb ready
  input wire        pslverr,               // apb error
  input wire        sample_valid,          // reading strobe
  input wire        board_fan_cruise,      // board cruise
  input wire        processor_fan_cruise,  // cpu cruise
  input wire [7:0]  board_fan_duty,        // board duty in
  input wire [7:0]  processor_fan_duty,    // cpu duty in
  input wire [7:0]  board_fan_drive,       // board duty out
  input wire [7:0]  processor_fan_drive,   // cpu duty out
  input wire        overheat_alert_out_n,  // alert pin
  input wire        irq                    // level interrupt
);
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);
  // ----------------------------------------
  // bus phases
  // ----------------------------------------
  sequence s_setup; psel && !penable; endsequence
  sequence s_access; psel && penable; endsequence
  property p_ready_lat; s_setup ##1 s_access |=> pready; endproperty
  property p_ready_one; pready |=> !pready; endproperty
  property p_err_data; pslverr |-> pready && prdata == 32'h0; endproperty
  property p_rd_upper; pready |-> prdata[31:8] == 24'h0; endproperty
  // ----------------------------------------
  // outputs
  // ----------------------------------------
  // outside cruise the duty request must pass untouched
  property p_board_pass;
    presetn && !board_fan_cruise |=> board_fan_drive == $past(board_fan_duty);
  endproperty
  property p_cpu_pass;
    presetn && !processor_fan_cruise |=> processor_fan_drive == $past(processor_fan_duty);
  endproperty
  // alert only enters two edges after a sample
  property p_alert_fall; $fell(overheat_alert_out_n) |-> $past(sample_valid, 2); endproperty
  // irq only drops after a clear or mask write
  property p_irq_fall; $fell(irq) |-> $past(pwrite && pready, 2); endproperty
  a_ready_lat: assert property (p_ready_lat) else $error("ready late");
  a_ready_one: assert property (p_ready_one) else $error("ready held");
  a_err_data: assert property (p_err_data) else $error("error data");
  a_rd_upper: assert property (p_rd_upper) else $error("upper data");
  a_board_pass: assert property (p_board_pass) else $error("board drive");
  a_cpu_pass: assert property (p_cpu_pass) else $error("cpu drive");
  a_alert_fall: assert property (p_alert_fall) else $error("alert early");
  a_irq_fall: assert property (p_irq_fall) else $error("irq drop");
endmodule  // tla_limit_regs_asserts

bind tla_limit_regs tla_limit_regs_asserts u_chk (.pclk, .presetn, .psel, .penable,
  .pwrite, .prdata, .pready, .pslverr, .sample_valid, .board_fan_cruise,
  .processor_fan_cruise, .board_fan_duty, .processor_fan_duty, .board_fan_drive,
  .processor_fan_drive, .overheat_alert_out_n, .irq);

// ==== tb/temp_limit_alert_regs_bench.sv ====
`timescale 1ns/1ps
module temp_limit_alert_regs_bench;
  typedef struct packed {
    logic       wr;   // write row
    logic       bad;  // high address bit set
    logic [7:0] idx;  // register index
    logic [7:0] wd;   // write data
    logic [7:0] exp;  // expected read
    logic       err;  // expected error
  } tla_row_t;
  logic        pclk, presetn, psel, penable, pwrite, sample_valid, cpu_src_sel, er;
  logic        board_fan_cruise, processor_fan_cruise, pready, pslverr, irq;
  logic        overheat_alert_out_n;
  logic [11:0] paddr;
  logic [31:0] pwdata, prdata;
  logic [8:0]  cpu_temp_input, board_temp_input, peci_temp;
  logic [1:0]  board_src_sel;
  logic [7:0]  board_fan_duty, processor_fan_duty, board_fan_drive, processor_fan_drive, rd, e;
  int          mismatches, cmp_count, cyc;
  tla_row_t    rows [21];

  tla_limit_regs dut (.pclk, .presetn, .paddr, .psel, .penable, .pwrite, .pwdata, .prdata,
    .pready, .pslverr, .cpu_temp_input, .board_temp_input, .peci_temp, .sample_valid,
    .cpu_src_sel, .board_src_sel, .board_fan_cruise, .processor_fan_cruise, .board_fan_duty,
    .processor_fan_duty, .board_fan_drive, .processor_fan_drive, .overheat_alert_out_n, .irq);

  // ----------------------------------------
  // clock, timeout, report
  // ----------------------------------------
  initial begin
    pclk = 1'b0;
    forever #5 pclk = ~pclk;
  end
  // whole run is well under a thousand cycles
  always @(posedge pclk) begin
    cyc <= cyc + 1;
    if (cyc == 5000) begin
      mismatches++;
      end_sim;
    end
  end
  task end_sim;
    $display("mismatches %0d compares %0d", mismatches, cmp_count);
    if (mismatches == 0 && cmp_count > 0)
      $display("Simulation passed");
    else
      $display("Simulation failed");
    $finish;
  endtask
  task chk(input string nm, input logic [7:0] x, g);
    cmp_count++;
    if (g !== x) begin
      mismatches++;
      $display("BAD %s expected %h seen %h", nm, x, g);
    end
  endtask

  // ----------------------------------------
  // bus and sample drivers
  // ----------------------------------------
  // request held until ready is seen at an edge
  task apb(input logic bad, wr, input logic [7:0] i, d);
    int n;
    @(posedge pclk);
    psel    <= 1'b1;
    penable <= 1'b0;
    pwrite  <= wr;
    paddr   <= {1'b0, bad, i, 2'b00};
    pwdata  <= {24'h0, d};
    @(posedge pclk);
    penable <= 1'b1;
    n = 0;
    do begin
      @(posedge pclk);
      n++;
    end while (pready !== 1'b1 && n < 20);
    if (n >= 20) mismatches++;
    rd = prdata[7:0];
    er = pslverr;
    psel    <= 1'b0;
    penable <= 1'b0;
  endtask
  task w(input logic [7:0] i, d);
    apb(1'b0, 1'b1, i, d);
  endtask
  task r(input logic [7:0] i, x);
    apb(1'b0, 1'b0, i, 8'h00);
    chk("rdata", x, rd);
  endtask
  task smp(input logic [8:0] t, input logic x);
    @(posedge pclk);
    cpu_temp_input <= t;
    sample_valid   <= 1'b1;
    @(posedge pclk);
    sample_valid <= 1'b0;
    repeat (3) @(posedge pclk);
    chk("alert_n", {7'h0, x}, {7'h0, overheat_alert_out_n});
  endtask
  // waits only; the caller samples after it, not at the call
  task hold;
    repeat (4) @(posedge pclk);
  endtask

  // ----------------------------------------
  // main sequence
  // ----------------------------------------
  initial begin
    {psel, penable, pwrite, sample_valid, cpu_src_sel, presetn} = 6'h0;
    {board_fan_cruise, processor_fan_cruise, board_src_sel} = 4'h0;
    paddr = 12'h000;
    pwdata = 32'h0;
    board_fan_duty = 8'h33;
    processor_fan_duty = 8'h44;
    cpu_temp_input = 9'h0a5;
    board_temp_input = 9'h0a1;
    peci_temp = 9'h13c;
    mismatches = 0;
    cmp_count = 0;
    cyc = 0;
    // wr, bad, index, write data, expected, error
    rows = '{'{0,0,8'h5e,0,8'h00,0}, '{0,0,8'h6b,0,8'hff,0}, '{0,0,8'h6c,0,8'hff,0},
      '{1,0,8'h6b,8'h5a,0,0}, '{0,0,8'h6b,0,8'h5a,0}, '{0,0,8'h50,0,8'h00,1},
      '{1,0,8'h40,8'h01,0,0}, '{0,0,8'h53,0,8'h4b,0}, '{0,0,8'h54,0,8'h00,0},
      '{0,0,8'h55,0,8'h50,0}, '{0,0,8'h56,0,8'h00,0}, '{0,0,8'h52,0,8'h00,0},
      '{1,0,8'h54,8'hff,0,0}, '{0,0,8'h54,0,8'h80,0},
      '{1,0,8'h52,8'h1b,0,0}, '{0,0,8'h52,0,8'h1b,0}, '{0,0,8'h50,0,8'h52,0},
      '{0,0,8'h51,0,8'h80,0}, '{1,0,8'h50,8'h00,0,0}, '{0,0,8'h50,0,8'h52,0},
      '{0,1,8'h40,0,8'h00,1}};
    repeat (20) @(posedge pclk);
    chk("alert_n", 8'h01, {7'h0, overheat_alert_out_n});
    chk("irq", 8'h00, {7'h0, irq});
    presetn <= 1'b1;
    foreach (rows[k]) begin
      apb(rows[k].bad, rows[k].wr, rows[k].idx, rows[k].wd);
      if (!rows[k].wr) chk("rdata", rows[k].exp, rd);
      chk("err", {7'h0, rows[k].err}, {7'h0, er});
    end
    cpu_src_sel <= 1'b1;
    r(8'h50, 8'h9e);
    cpu_src_sel <= 1'b0;
    w(8'h40, 8'h02);
    for (int s = 0; s < 4; s++) begin
      board_src_sel <= 2'(s);
      e = s == 1 ? cpu_temp_input[8:1] : s == 2 ? peci_temp[8:1] : board_temp_input[8:1];
      r(8'h50, e);
    end
    r(8'h51, 8'h80);
    // comparator mode, two faults needed
    w(8'h40, 8'h01);
    w(8'h52, 8'h08);
    smp(9'h0a1, 1'b1);
    smp(9'h0a0, 1'b1);
    smp(9'h0a1, 1'b1);
    smp(9'h0a1, 1'b0);
    smp(9'h097, 1'b0);
    smp(9'h095, 1'b1);
    // interrupt mode latches until status read
    w(8'h52, 8'h02);
    smp(9'h0a1, 1'b0);
    smp(9'h050, 1'b0);
    r(8'h41, 8'h01);
    hold;
    chk("alert_n", 8'h01, {7'h0, overheat_alert_out_n});
    w(8'h52, 8'h03);
    smp(9'h0a1, 1'b1);
    // fan override and interrupt
    w(8'h40, 8'h00);
    w(8'h41, 8'h07);
    w(8'h42, 8'h07);
    w(8'h5e, 8'h30);
    w(8'h6b, 8'h40);
    w(8'h6c, 8'h50);
    board_fan_cruise <= 1'b1;
    processor_fan_cruise <= 1'b1;
    hold;
    chk("board_drive", 8'hff, board_fan_drive);
    chk("cpu_drive", 8'h44, processor_fan_drive);
    w(8'h6c, 8'h4f);
    hold;
    chk("cpu_drive", 8'hff, processor_fan_drive);
    r(8'h41, 8'h06);
    chk("irq", 8'h01, {7'h0, irq});
    w(8'h42, 8'h00);
    hold;
    chk("irq", 8'h00, {7'h0, irq});
    w(8'h42, 8'h07);
    hold;
    chk("irq", 8'h01, {7'h0, irq});
    w(8'h41, 8'h06);
    hold;
    chk("irq", 8'h00, {7'h0, irq});
    w(8'h5e, 8'h10);
    hold;
    chk("cpu_drive", 8'h44, processor_fan_drive);
    board_fan_cruise <= 1'b0;
    hold;
    chk("board_drive", 8'h33, board_fan_drive);
    end_sim;
  end
endmodule  // temp_limit_alert_regs_bench
